// file: hw/pctw_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PCTW_DEFS_SVH
`define PCTW_DEFS_SVH

// ---------------------------------------------------------------
// Byte addresses
// ---------------------------------------------------------------
`define PCTW_A_T24_CTRL 8'h00
`define PCTW_A_T24_CMP0 8'h04
`define PCTW_A_T24_CMP1 8'h08
`define PCTW_A_T24_CNT  8'h0C
`define PCTW_A_T24_CAP0 8'h10
`define PCTW_A_T24_CAP1 8'h14
`define PCTW_A_T24_STAT 8'h18
`define PCTW_A_WDT_CTRL 8'h80
`define PCTW_A_WDT_KEY  8'h84
`define PCTW_T16_PAGE   2'h1
`define PCTW_O_CTRL     4'h0
`define PCTW_O_CMP0     4'h4
`define PCTW_O_CMP1     4'h8
`define PCTW_O_STAT     4'hC

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define PCTW_F_PRE   7:0
`define PCTW_F_RST   9:8
`define PCTW_F_ACT   11:10
`define PCTW_F_ACT1  13:12
`define PCTW_F_GPIO  14
`define PCTW_F_EN    15
`define PCTW_F_SWR   16
`define PCTW_F_IEN24 21:17
`define PCTW_F_IEN16 19:17
`define PCTW_F_CE0   23:22
`define PCTW_F_CE1   25:24
`define PCTW_WMASK24 26'h3FEFFFF
`define PCTW_WMASK16 26'h00EFFFF

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define PCTW_RST_CTRL 26'h0000000
`define PCTW_WDT_TOUT 17'h10000

`endif

// file: hw/pctw_pkg.sv
// Types and helpers of the timer unit
package pctw_pkg;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      RST_ROLL = 2'h0,
      RST_CMP0 = 2'h1,
      RST_CMP1 = 2'h2
   } pctw_rst_e;

   typedef enum logic [1:0] {
      ACT_NONE = 2'h0,
      ACT_SET  = 2'h1,
      ACT_CLR  = 2'h2,
      ACT_TOG  = 2'h3
   } pctw_act_e;

   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_BOTH = 2'h2,
      EDGE_OFF  = 2'h3
   } pctw_edge_e;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       pre_cnt;
      logic [23:0]      cnt;
      logic [1:0][23:0] cmp;
      logic [1:0][23:0] shadow;
      logic [1:0]       pend;
      logic [1:0][23:0] cap;
      logic [25:0]      ctrl;
      logic [4:0]       flg;
      logic             pin;
      logic             irq;
      logic [1:0][2:0]  csync;
      logic [1:0]       psync;
   } pctw_t24_t;

   typedef struct packed {
      logic [7:0]       pre_cnt;
      logic [15:0]      cnt;
      logic [1:0][15:0] cmp;
      logic [1:0][15:0] shadow;
      logic [1:0]       pend;
      logic [25:0]      ctrl;
      logic [2:0]       flg;
      logic             pin;
      logic             irq;
      logic [1:0]       psync;
   } pctw_t16_t;

   typedef struct packed {
      logic [2:0]  osc;
      logic [16:0] cnt;
      logic        en;
      logic        half;
      logic        rst;
   } pctw_wdt_t;

   typedef struct packed {
      pctw_t24_t       t24;
      pctw_t16_t [3:0] t16;
      pctw_wdt_t       wdt;
      logic            rdy;
      logic [31:0]     rdata;
      logic            slverr;
   } pctw_state_t;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic pctw_act_f(input logic [1:0] a,
                                       input logic       p);
      case (a)
         ACT_SET: pctw_act_f = 1'b1;
         ACT_CLR: pctw_act_f = 1'b0;
         ACT_TOG: pctw_act_f = ~p;
         default: pctw_act_f = p;
      endcase
   endfunction : pctw_act_f

   function automatic logic pctw_edge_f(input logic [1:0] m,
                                        input logic [2:0] sy);
      logic r;
      logic f;
      r = sy[1] & ~sy[2];
      f = ~sy[1] & sy[2];
      case (m)
         EDGE_RISE: pctw_edge_f = r;
         EDGE_FALL: pctw_edge_f = f;
         EDGE_BOTH: pctw_edge_f = r | f;
         default:   pctw_edge_f = 1'b0;
      endcase
   endfunction : pctw_edge_f

endpackage : pctw_pkg

// file: hw/pctw_top.sv
// Timer unit: 24-bit capture timer, four 16-bit timers, watchdog
`timescale 1ns/1ns
`include "pctw_defs.svh"

module pctw_top #(
   parameter logic [16:0] WDT_TOUT = `PCTW_WDT_TOUT
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output wire logic        pready,
   output wire logic [31:0] prdata,
   output wire logic        pslverr,
   input  wire logic        capture_input_zero,
   input  wire logic        capture_input_one,
   input  wire logic        timer_output_pin_in,
   output wire logic        timer_output_pin_out,
   output wire logic        timer_output_pin_oe_n,
   output wire logic        t24_irq,
   input  wire logic [3:0]  t16_pin_in,
   output wire logic [3:0]  t16_pin_out,
   output wire logic [3:0]  t16_pin_oe_n,
   output wire logic [3:0]  t16_irq,
   input  wire logic        wdt_osc,
   output wire logic        wdt_cpu_reset
);
   import pctw_pkg::*;

   localparam logic [16:0] WDT_HALF = WDT_TOUT >> 1;

   pctw_state_t      s;
   pctw_state_t      next_s;
   logic             tick24;
   logic             ov24;
   logic [1:0]       ev24;
   logic [1:0]       cap_ev;
   logic [3:0]       tick16;
   logic [3:0]       ov16;
   logic [3:0][1:0]  ev16;
   logic             wtick;
   logic             wd_restart;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic        acc;
      logic        wr;
      logic        hit;
      logic        pg16;
      logic [31:0] rv;
      logic [4:0]  clr24;
      logic [2:0]  clr16;
      logic        lvl;
      acc    = psel & penable;
      wr     = acc & s.rdy & pwrite;
      hit    = 1'b1;
      pg16   = paddr[7:6] == `PCTW_T16_PAGE;
      rv     = 32'h0;
      clr24  = 5'h0;
      clr16  = 3'h0;
      lvl    = 1'b0;
      next_s = s;

      // Bus handshake, one wait state
      next_s.rdy    = acc & ~s.rdy;
      next_s.rdata  = 32'h0;
      next_s.slverr = 1'b0;

      // Synchronisers
      next_s.t24.csync[0] = {s.t24.csync[0][1:0], capture_input_zero};
      next_s.t24.csync[1] = {s.t24.csync[1][1:0], capture_input_one};
      next_s.t24.psync    = {s.t24.psync[0], timer_output_pin_in};
      next_s.wdt.osc      = {s.wdt.osc[1:0], wdt_osc};

      // ---------------------------------------------------------
      // 24-bit timer
      // ---------------------------------------------------------
      tick24 = s.t24.ctrl[`PCTW_F_EN] &&
               s.t24.pre_cnt == s.t24.ctrl[`PCTW_F_PRE];
      if (!s.t24.ctrl[`PCTW_F_EN]) begin
         next_s.t24.pre_cnt = 8'h00;
      end else if (tick24) begin
         next_s.t24.pre_cnt = 8'h00;
      end else begin
         next_s.t24.pre_cnt = s.t24.pre_cnt + 8'h01;
      end
      for (int k = 0; k < 2; k++) begin
         ev24[k] = tick24 && s.t24.cnt == s.t24.cmp[k];
      end
      ov24 = tick24 && (&s.t24.cnt);
      if (tick24) begin
         next_s.t24.cnt = s.t24.cnt + 24'h000001;
      end
      case (s.t24.ctrl[`PCTW_F_RST])
         RST_CMP0: if (ev24[0]) next_s.t24.cnt = 24'h0;
         RST_CMP1: if (ev24[1]) next_s.t24.cnt = 24'h0;
         default: ;
      endcase
      for (int k = 0; k < 2; k++) begin
         if (ev24[k] && s.t24.pend[k]) begin
            next_s.t24.cmp[k]  = s.t24.shadow[k];
            next_s.t24.pend[k] = 1'b0;
         end
      end
      cap_ev[0] = pctw_edge_f(s.t24.ctrl[`PCTW_F_CE0],
                              s.t24.csync[0]);
      cap_ev[1] = pctw_edge_f(s.t24.ctrl[`PCTW_F_CE1],
                              s.t24.csync[1]);
      for (int k = 0; k < 2; k++) begin
         if (cap_ev[k]) begin
            next_s.t24.cap[k] = s.t24.cnt;
         end
      end
      if (ev24[1]) begin
         next_s.t24.pin = pctw_act_f(s.t24.ctrl[`PCTW_F_ACT],
                                     s.t24.pin);
      end
      next_s.t24.irq = |(s.t24.flg & s.t24.ctrl[`PCTW_F_IEN24]);

      // ---------------------------------------------------------
      // 16-bit timers
      // ---------------------------------------------------------
      for (int i = 0; i < 4; i++) begin
         next_s.t16[i].psync = {s.t16[i].psync[0], t16_pin_in[i]};
         tick16[i] = s.t16[i].ctrl[`PCTW_F_EN] &&
                     s.t16[i].pre_cnt ==
                     s.t16[i].ctrl[`PCTW_F_PRE];
         if (!s.t16[i].ctrl[`PCTW_F_EN] || tick16[i]) begin
            next_s.t16[i].pre_cnt = 8'h00;
         end else begin
            next_s.t16[i].pre_cnt = s.t16[i].pre_cnt + 8'h01;
         end
         for (int k = 0; k < 2; k++) begin
            ev16[i][k] = tick16[i] &&
                         s.t16[i].cnt == s.t16[i].cmp[k];
         end
         ov16[i] = tick16[i] && (&s.t16[i].cnt);
         if (tick16[i]) begin
            next_s.t16[i].cnt = s.t16[i].cnt + 16'h0001;
         end
         case (s.t16[i].ctrl[`PCTW_F_RST])
            RST_CMP0: if (ev16[i][0]) next_s.t16[i].cnt = 16'h0;
            RST_CMP1: if (ev16[i][1]) next_s.t16[i].cnt = 16'h0;
            default: ;
         endcase
         for (int k = 0; k < 2; k++) begin
            if (ev16[i][k] && s.t16[i].pend[k]) begin
               next_s.t16[i].cmp[k]  = s.t16[i].shadow[k];
               next_s.t16[i].pend[k] = 1'b0;
            end
         end
         if (ev16[i][0]) begin
            next_s.t16[i].pin = pctw_act_f(s.t16[i].ctrl[`PCTW_F_ACT],
                                           s.t16[i].pin);
         end
         if (ev16[i][1]) begin
            next_s.t16[i].pin = pctw_act_f(s.t16[i].ctrl[`PCTW_F_ACT1],
                                           next_s.t16[i].pin);
         end
         next_s.t16[i].irq = |(s.t16[i].flg &
                               s.t16[i].ctrl[`PCTW_F_IEN16]);
      end

      // ---------------------------------------------------------
      // Watchdog
      // ---------------------------------------------------------
      wtick      = s.wdt.osc[1] & ~s.wdt.osc[2];
      wd_restart = wr && paddr == `PCTW_A_WDT_KEY && pwdata[0];
      if (wr && paddr == `PCTW_A_WDT_CTRL && pwdata[0]) begin
         next_s.wdt.en = 1'b1;
      end
      if (!s.wdt.en) begin
         next_s.wdt.cnt = 17'h0;
      end else if (wd_restart) begin
         next_s.wdt.cnt  = 17'h0;
         next_s.wdt.half = 1'b0;
      end else if (wtick && !s.wdt.rst) begin
         next_s.wdt.cnt = s.wdt.cnt + 17'h1;
         if (s.wdt.cnt + 17'h1 == WDT_HALF) begin
            next_s.wdt.half = 1'b1;
         end
         if (s.wdt.cnt + 17'h1 == WDT_TOUT) begin
            next_s.wdt.rst = 1'b1;
         end
      end

      // ---------------------------------------------------------
      // Register writes
      // ---------------------------------------------------------
      if (wr) begin
         case (paddr)
            `PCTW_A_T24_CTRL: begin
               next_s.t24.ctrl = pwdata[25:0] & `PCTW_WMASK24;
               if (pwdata[`PCTW_F_SWR]) begin
                  next_s.t24.cnt     = 24'h0;
                  next_s.t24.pre_cnt = 8'h00;
               end
            end
            `PCTW_A_T24_CMP0, `PCTW_A_T24_CMP1: begin
               if (s.t24.ctrl[`PCTW_F_EN]) begin
                  next_s.t24.shadow[paddr[3]] = pwdata[23:0];
                  next_s.t24.pend[paddr[3]]   = 1'b1;
               end else begin
                  next_s.t24.cmp[paddr[3]]  = pwdata[23:0];
                  next_s.t24.pend[paddr[3]] = 1'b0;
               end
            end
            `PCTW_A_T24_STAT: clr24 = pwdata[4:0];
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (pg16 && paddr[5:4] == 2'(i)) begin
                     case (paddr[3:0])
                        `PCTW_O_CTRL: begin
                           next_s.t16[i].ctrl = pwdata[25:0] &
                                                `PCTW_WMASK16;
                           if (pwdata[`PCTW_F_SWR]) begin
                              next_s.t16[i].cnt     = 16'h0;
                              next_s.t16[i].pre_cnt = 8'h00;
                           end
                        end
                        `PCTW_O_CMP0, `PCTW_O_CMP1: begin
                           if (s.t16[i].ctrl[`PCTW_F_EN]) begin
                              next_s.t16[i].shadow[paddr[3]] =
                                 pwdata[15:0];
                              next_s.t16[i].pend[paddr[3]] = 1'b1;
                           end else begin
                              next_s.t16[i].cmp[paddr[3]] =
                                 pwdata[15:0];
                              next_s.t16[i].pend[paddr[3]] = 1'b0;
                           end
                        end
                        `PCTW_O_STAT: clr16 = pwdata[18:16];
                        default: ;
                     endcase
                  end
               end
            end
         endcase
      end

      // Sticky flags, a set beats a clear
      next_s.t24.flg = (s.t24.flg & ~clr24) |
                       {ev24[1], ev24[0], cap_ev[1], cap_ev[0],
                        ov24};
      for (int i = 0; i < 4; i++) begin
         next_s.t16[i].flg = (s.t16[i].flg &
                              ~((pg16 && paddr[5:4] == 2'(i)) ?
                                clr16 : 3'h0)) |
                             {ev16[i][1], ev16[i][0], ov16[i]};
      end

      // ---------------------------------------------------------
      // Register reads
      // ---------------------------------------------------------
      lvl = s.t24.ctrl[`PCTW_F_GPIO] ? s.t24.psync[1] : s.t24.pin;
      case (paddr)
         `PCTW_A_T24_CTRL: rv = {6'h0, s.t24.ctrl};
         `PCTW_A_T24_CMP0: rv = {8'h0, s.t24.cmp[0]};
         `PCTW_A_T24_CMP1: rv = {8'h0, s.t24.cmp[1]};
         `PCTW_A_T24_CNT:  rv = {8'h0, s.t24.cnt};
         `PCTW_A_T24_CAP0: rv = {8'h0, s.t24.cap[0]};
         `PCTW_A_T24_CAP1: rv = {8'h0, s.t24.cap[1]};
         `PCTW_A_T24_STAT: rv = {26'h0, lvl, s.t24.flg};
         `PCTW_A_WDT_CTRL: rv = {29'h0, s.wdt.rst, s.wdt.half,
                                 s.wdt.en};
         `PCTW_A_WDT_KEY:  rv = 32'h0;
         default: begin
            hit = 1'b0;
            for (int i = 0; i < 4; i++) begin
               if (pg16 && paddr[5:4] == 2'(i)) begin
                  hit = 1'b1;
                  case (paddr[3:0])
                     `PCTW_O_CTRL: rv = {6'h0, s.t16[i].ctrl};
                     `PCTW_O_CMP0: rv = {16'h0, s.t16[i].cmp[0]};
                     `PCTW_O_CMP1: rv = {16'h0, s.t16[i].cmp[1]};
                     `PCTW_O_STAT: rv = {12'h0,
                        s.t16[i].ctrl[`PCTW_F_GPIO] ?
                        s.t16[i].psync[1] : s.t16[i].pin,
                        s.t16[i].flg, s.t16[i].cnt};
                     default: hit = 1'b0;
                  endcase
               end
            end
         end
      endcase
      if (acc && !s.rdy) begin
         next_s.rdata  = hit ? rv : 32'h0;
         next_s.slverr = ~hit;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign pready                = s.rdy;
   assign prdata                = s.rdata;
   assign pslverr               = s.slverr;
   assign timer_output_pin_out  = s.t24.pin;
   assign timer_output_pin_oe_n = s.t24.ctrl[`PCTW_F_GPIO];
   assign t24_irq               = s.t24.irq;
   assign wdt_cpu_reset         = s.wdt.rst;

   for (genvar g = 0; g < 4; g++) begin : g_t16_out
      assign t16_pin_out[g]  = s.t16[g].pin;
      assign t16_pin_oe_n[g] = s.t16[g].ctrl[`PCTW_F_GPIO];
      assign t16_irq[g]      = s.t16[g].irq;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_cap0;
      ce && cap_ev[0];
   endsequence

   sequence s_wd_step(logic [16:0] at);
      ce && wtick && s.wdt.en && !wd_restart && !s.wdt.rst &&
      s.wdt.cnt == at;
   endsequence

   apb_ready_a: assert property (
      ce && psel && penable && !pready |=> pready ##1 !pready or
      !ce)
      else $error("pready not given after wait state");
   cap_copy_a: assert property (
      s_cap0 |=> s.t24.cap[0] == $past(s.t24.cnt))
      else $error("capture did not copy count");
   cmp_load_a: assert property (
      ce && ev24[0] && s.t24.pend[0] |=>
      s.t24.cmp[0] == $past(s.t24.shadow[0]) && !s.t24.pend[0])
      else $error("shadow compare not loaded");
   cmp0_pin_a: assert property (
      ce && ev24[0] && !ev24[1] |=> $stable(timer_output_pin_out))
      else $error("first compare moved the pin");
   cmp1_tog_a: assert property (
      ce && ev24[1] && s.t24.ctrl[`PCTW_F_ACT] == ACT_TOG |=>
      timer_output_pin_out != $past(timer_output_pin_out))
      else $error("toggle action missing");
   ovf_wrap_a: assert property (
      ce && ov24 |=> s.t24.cnt == 24'h0 && s.t24.flg[0])
      else $error("overflow not wrapped or flagged");
   cmp_clear_a: assert property (
      ce && ev24[1] && s.t24.ctrl[`PCTW_F_RST] == RST_CMP1 |=>
      s.t24.cnt == 24'h0)
      else $error("compare reset did not clear count");
   t16_set_a: assert property (
      ce && ev16[0][0] && !ev16[0][1] &&
      s.t16[0].ctrl[`PCTW_F_ACT] == ACT_SET |=> t16_pin_out[0])
      else $error("16-bit set action missing");
   wdt_lock_a: assert property (
      s.wdt.en |=> s.wdt.en)
      else $error("watchdog enable dropped");
   wdt_half_a: assert property (
      s_wd_step(WDT_HALF - 17'h1) |=> s.wdt.half)
      else $error("half flag not set");
   wdt_expire_a: assert property (
      s_wd_step(WDT_TOUT - 17'h1) |=> wdt_cpu_reset [*2])
      else $error("expiry gave no reset");

endmodule : pctw_top

// file: bench/pctw_far.sv
// Far side model: capture sources, pin loads, slow oscillator
`timescale 1ns/1ns
module pctw_far (
   input  wire logic       pclk,
   input  wire logic       pin_out,
   input  wire logic       pin_oe_n,
   input  wire logic [3:0] t16_out,
   input  wire logic [3:0] t16_oe_n,
   output logic            cap0,
   output logic            cap1,
   output logic            pin_in,
   output logic [3:0]      t16_in,
   output logic            osc
);
   logic ext = 1'b0;
   initial begin
      cap0 = 1'b0;
      cap1 = 1'b0;
      osc = 1'b0;
      forever #150 osc = ~osc;
   end
   // Wire level from both drivers
   assign pin_in = pin_oe_n ? ext : pin_out;
   assign t16_in = (~t16_oe_n & t16_out) | (t16_oe_n & {4{ext}});
   task automatic set_cap(input int i, input logic v);
      @(posedge pclk);
      if (i == 0) cap0 <= v;
      else cap1 <= v;
   endtask : set_cap
endmodule : pctw_far

// file: bench/pwm_capture_timers_watchdog_bench.sv
// Self-checking bench of the timer unit
`timescale 1ns/1ns
module pwm_capture_timers_watchdog_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, c0;
   logic        pready, pslverr, err, cap0, cap1, pin_in, pin_out;
   logic        pin_oe_n, t24_irq, osc, wdt_cpu_reset;
   logic [3:0]  t16_in, t16_out, t16_oe_n, t16_irq;
   logic [7:0]  a;
   logic [31:0] cap_q[$];
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   pctw_top #(.WDT_TOUT(17'd8)) DUT (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .capture_input_zero(cap0),
      .capture_input_one(cap1), .timer_output_pin_in(pin_in),
      .timer_output_pin_out(pin_out), .timer_output_pin_oe_n(pin_oe_n),
      .t24_irq(t24_irq), .t16_pin_in(t16_in), .t16_pin_out(t16_out),
      .t16_pin_oe_n(t16_oe_n), .t16_irq(t16_irq), .wdt_osc(osc),
      .wdt_cpu_reset(wdt_cpu_reset));
   pctw_far far (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .t16_out(t16_out), .t16_oe_n(t16_oe_n), .cap0(cap0), .cap1(cap1),
      .pin_in(pin_in), .t16_in(t16_in), .osc(osc));
   initial begin
      forever #25 pclk = ~pclk;
   end
   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_mismatch++;
         close_out;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // One APB transfer, held until pready is seen
   task automatic bus(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] m,
                        input logic [31:0] e);
      bus(1'b0, ad, 32'h0);
      chk(rd & m, e);
   endtask : rdchk
   initial begin
      void'($urandom(32'hEE0A9C3B));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(8'h00, 32'hFFFFFFFF, 32'h0);
      rdchk(8'h80, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 8'h3C, 32'h1);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
      for (int k = 0; k < 2; k++) begin
         c0 = 1 + $urandom % 8;
         bus(1'b1, 8'h04, c0);
         bus(1'b1, 8'h08, c0 + 6);
         bus(1'b1, 8'h00, 32'h108400 | ((k + 1) << 8));
         repeat (40) @(negedge pclk);
         chk({31'h0, t24_irq}, 32'h1);
         rdchk(8'h18, 32'h3F, k ? 32'h38 : 32'h08);
         bus(1'b1, 8'h00, 32'h10000);
         rdchk(8'h0C, 32'hFFFFFF, 32'h0);
         chk({31'h0, t24_irq}, 32'h0);
         bus(1'b1, 8'h18, 32'h1F);
         rdchk(8'h18, 32'h1F, 32'h0);
      end
      $display("compare test done");
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b1, 8'h08, 32'h2);
      bus(1'b1, 8'h00, 32'h8EFF);
      bus(1'b1, 8'h04, 32'h5);
      bus(1'b1, 8'h08, 32'h9);
      rdchk(8'h04, 32'hFFFFFF, 32'h1);
      rdchk(8'h08, 32'hFFFFFF, 32'h2);
      repeat (1000) @(negedge pclk);
      rdchk(8'h04, 32'hFFFFFF, 32'h5);
      rdchk(8'h08, 32'hFFFFFF, 32'h9);
      rdchk(8'h18, 32'h20, 32'h0);
      $display("shadow test done");
      bus(1'b1, 8'h00, 32'h1018000);
      repeat (5 + $urandom % 20) @(negedge pclk);
      bus(1'b0, 8'h0C, 32'h0);
      c0 = rd;
      ce <= 1'b0;
      repeat (20) @(posedge pclk);
      ce <= 1'b1;
      rdchk(8'h0C, 32'hFFFFFF, c0 + 4);
      bus(1'b1, 8'h00, 32'h1000000);
      bus(1'b0, 8'h0C, 32'h0);
      c0 = rd;
      cap_q.push_back(c0);
      cap_q.push_back(c0);
      bus(1'b1, 8'h18, 32'h1F);
      far.set_cap(0, 1'b1);
      far.set_cap(1, 1'b1);
      repeat (8) @(negedge pclk);
      rdchk(8'h18, 32'h06, 32'h02);
      rdchk(8'h10, 32'hFFFFFF, cap_q.pop_front());
      far.set_cap(1, 1'b0);
      repeat (8) @(negedge pclk);
      rdchk(8'h14, 32'hFFFFFF, cap_q.pop_front());
      $display("capture test done");
      for (int v = 0; v < 2; v++) begin
         far.ext <= v[0];
         bus(1'b1, 8'h00, 32'h4000);
         rdchk(8'h18, 32'h20, {26'h0, v[0], 5'h0});
         chk({31'h0, pin_oe_n}, 32'h1);
      end
      $display("gpio test done");
      for (int i = 0; i < 4; i++) begin
         a = 8'h40 + 8'(16 * i);
         bus(1'b1, a + 8'h4, 32'h3);
         bus(1'b1, a + 8'h8, 32'hFFFF);
         bus(1'b1, a, 32'h48400);
         repeat (30) @(negedge pclk);
         rdchk(a + 8'hC, 32'hF0000, 32'hA0000);
         chk({31'h0, t16_out[i]}, 32'h1);
         chk({31'h0, t16_oe_n[i]}, 32'h0);
         chk({31'h0, t16_irq[i]}, 32'h1);
         bus(1'b1, a, 32'h10000);
         rdchk(a + 8'hC, 32'hFFFF, 32'h0);
         chk({31'h0, t16_irq[i]}, 32'h0);
      end
      $display("t16 test done");
      bus(1'b1, 8'h80, 32'h1);
      bus(1'b1, 8'h84, 32'h1);
      repeat (2) @(posedge osc);
      rdchk(8'h80, 32'h7, 32'h1);
      repeat (3) @(posedge osc);
      rdchk(8'h80, 32'h7, 32'h3);
      bus(1'b1, 8'h84, 32'h1);
      bus(1'b1, 8'h80, 32'h0);
      rdchk(8'h80, 32'h7, 32'h1);
      repeat (14) @(posedge osc);
      chk({31'h0, wdt_cpu_reset}, 32'h1);
      rdchk(8'h80, 32'h7, 32'h7);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(8'h80, 32'h7, 32'h0);
      chk({31'h0, wdt_cpu_reset}, 32'h0);
      $display("watchdog test done");
      close_out;
   end
endmodule : pwm_capture_timers_watchdog_bench
